// ### tb/dfarb_arbiter_tb_top.sv
// Purpose: self-checking bench for the dual function request arbiter
// Assumes: inputs driven 1 ns after the rising clock edge
// Notes: grants are {audio, video}; the bench plays both initiators
`timescale 1ns/10ps
module dfarb_arbiter_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gnt_n, req_n, lock_en = 1'b0, gate_en = 1'b0, allow = 1'b0, park = 1'b0;
  dfarb_pkg::dfarb_bus_s bus = 2'b11;
  dfarb_pkg::dfarb_func_s req = 2'b00;
  dfarb_pkg::dfarb_func_s gnt;
  int n_mismatch = 0;
  int n_checks = 0;

  dfarb_arbiter dut_u (.i_clk(clk), .i_rst(rst), .i_gnt_n(gnt_n), .i_bus(bus),
    .i_func_req(req), .i_chipset_request_lock_enable(lock_en),
    .i_grant_gating_enable(gate_en), .o_req_n(req_n), .o_func_gnt(gnt));
  dfarb_ext_arbiter ext_u (.i_clk(clk), .i_rst(rst), .i_req_n(req_n),
    .i_allow(allow), .i_park(park), .o_gnt_n(gnt_n));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic t_park();
    park = 1'b1;
    allow = 1'b1;
    step(2);
    chk("park_gnt", 2'h1, gnt);
    park = 1'b0;
    allow = 1'b0;
    step(2);
    $display("test park done");
  endtask

  task automatic t_normal();
    req.video = 1'b1;
    step(1);
    chk("or_req", 2'h0, {1'b0, req_n});
    req.audio = 1'b1;
    step(1);
    allow = 1'b1;
    step(1);
    chk("audio_wins", 2'h2, gnt);
    step(1);
    bus = 2'h0;
    step(1);
    req.audio = 1'b0;
    step(1);
    chk("no_preempt", 2'h2, gnt);
    bus = 2'h3;
    step(2);
    chk("back_to_video", 2'h1, gnt);
    req = 2'h0;
    allow = 1'b0;
    step(2);
    $display("test normal done");
  endtask

  task automatic t_lock();
    lock_en = 1'b1;
    step(1);
    req = 2'h3;
    step(1);
    chk("lock_or", 2'h0, {1'b0, req_n});
    allow = 1'b1;
    step(1);
    chk("lock_gnt", 2'h2, gnt);
    // frame follows the cycle in which the grant is seen
    step(1);
    // initiator drops request with frame, no re-request
    bus = 2'h0;
    req.audio = 1'b0;
    step(1);
    chk("lock_block", 2'h1, {1'b0, req_n});
    step(1);
    chk("lock_hold", 2'h1, {1'b0, req_n});
    bus = 2'h3;
    step(2);
    chk("lock_free", 2'h0, {1'b0, req_n});
    req = 2'h0;
    lock_en = 1'b0;
    allow = 1'b0;
    step(2);
    $display("test lock done");
  endtask

  task automatic t_gate();
    // gating set only for a non-compliant host
    gate_en = 1'b1;
    park = 1'b1;
    allow = 1'b1;
    step(3);
    chk("gate_nopark", 2'h0, gnt);
    req.video = 1'b1;
    step(1);
    chk("gate_pass", 2'h1, gnt);
    req = 2'h0;
    gate_en = 1'b0;
    park = 1'b0;
    allow = 1'b0;
    step(2);
    $display("test gate done");
  endtask

  task automatic t_reset();
    lock_en = 1'b1;
    req = 2'h3;
    bus = 2'h0;
    allow = 1'b1;
    step(3);
    chk("rst_pre_lock", 2'h2, gnt);
    // mid-run reset while the decision is frozen on audio
    rst = 1'b1;
    bus = 2'h3;
    req = 2'h1;
    step(2);
    rst = 1'b0;
    chk("rst_no_gnt", 2'h0, gnt);
    step(1);
    chk("rst_video_gnt", 2'h1, gnt);
    chk("rst_req_pin", 2'h0, {1'b0, req_n});
    req = 2'h0;
    lock_en = 1'b0;
    allow = 1'b0;
    step(2);
    $display("test reset done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    step(2);
    rst = 1'b0;
    step(1);
    t_park();
    t_normal();
    t_lock();
    t_gate();
    t_reset();
    give_verdict();
  end
endmodule // dfarb_arbiter_tb_top

// ### tb/dfarb_ext_arbiter.sv
// Purpose: model of the external pci arbiter facing the request pin
// Assumes: grant is registered one clock after the request is seen
// Notes: park grants with no request, allow low withholds the grant
`timescale 1ns/10ps
module dfarb_ext_arbiter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_n,
  input wire logic i_allow,
  input wire logic i_park,
  output logic o_gnt_n
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_gnt_n <= 1'b1;
    end else begin
      o_gnt_n <= ~(i_allow & (~i_req_n | i_park));
    end
  end
endmodule // dfarb_ext_arbiter

// ### verilog/dfarb_arbiter.sv
// Purpose: share one pci request/grant pair between video and audio dma
// Assumes: single pci clock domain, grant and bus phase already synchronous
// Notes: grant steering is combinational from the grant pin
`timescale 1ns/10ps
module dfarb_arbiter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_gnt_n,
  input wire dfarb_pkg::dfarb_bus_s i_bus,
  input wire dfarb_pkg::dfarb_func_s i_func_req,
  input wire logic i_chipset_request_lock_enable,
  input wire logic i_grant_gating_enable,
  output logic o_req_n,
  output dfarb_pkg::dfarb_func_s o_func_gnt
);

  logic lock_en_q;
  logic gate_en_q;
  logic locked_q;
  logic busy_q;
  logic owner_q;
  logic prev_sel_q;
  logic gnt_q;
  logic gnt;
  logic idle;
  logic start;
  logic sel_comb;
  logic sel;
  logic lock_active;
  logic req;
  logic gnt_int;
  logic [1:0] req_vec;

  assign gnt = ~i_gnt_n;
  assign idle = i_bus.frame_n & i_bus.irdy_n;
  assign req_vec = {i_func_req.audio, i_func_req.video};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_en_q <= dfarb_pkg::RST_MODE;
      gate_en_q <= dfarb_pkg::RST_MODE;
    end else begin
      lock_en_q <= i_chipset_request_lock_enable;
      gate_en_q <= i_grant_gating_enable;
    end
  end

  assign sel_comb = i_func_req.audio ? dfarb_pkg::FUNC_AUDIO : dfarb_pkg::FUNC_VIDEO;
  // normal mode: transaction begins when frame follows a grant
  assign start = ~lock_en_q & ~busy_q & gnt_q & ~i_bus.frame_n;

  always_comb begin
    if (lock_en_q) begin
      sel = locked_q ? owner_q : sel_comb;
    end else if (busy_q) begin
      sel = owner_q;
    end else if (start) begin
      sel = prev_sel_q;
    end else begin
      sel = sel_comb;
    end
  end

  assign lock_active = lock_en_q & (locked_q | gnt);

  always_comb begin
    if (lock_active) begin
      req = req_vec[sel];
    end else begin
      req = |req_vec;
    end
  end
  assign o_req_n = ~req;

  assign gnt_int = gnt & (~gate_en_q | req);

  always_comb begin
    o_func_gnt.video = gnt_int & (sel == dfarb_pkg::FUNC_VIDEO);
    o_func_gnt.audio = gnt_int & (sel == dfarb_pkg::FUNC_AUDIO);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      locked_q <= dfarb_pkg::RST_LOCKED;
    end else if (!lock_en_q) begin
      locked_q <= dfarb_pkg::RST_LOCKED;
    end else if (locked_q && idle) begin
      locked_q <= 1'b0;
    end else if (!locked_q && gnt) begin
      locked_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= dfarb_pkg::RST_BUSY;
    end else if (lock_en_q) begin
      busy_q <= dfarb_pkg::RST_BUSY;
    end else if (busy_q && idle) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      owner_q <= dfarb_pkg::RST_OWNER;
      prev_sel_q <= dfarb_pkg::RST_OWNER;
      gnt_q <= 1'b0;
    end else begin
      prev_sel_q <= sel;
      gnt_q <= gnt;
      if (lock_en_q && !locked_q && gnt) begin
        owner_q <= sel;
      end else if (start) begin
        owner_q <= prev_sel_q;
      end
    end
  end

  property p_one_grant;
    @(posedge i_clk) disable iff (i_rst)
      !(o_func_gnt.video && o_func_gnt.audio);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("both functions granted");

  // parked grant follows request-free steering to video
  property p_park_video;
    @(posedge i_clk) disable iff (i_rst)
      (!gate_en_q && !locked_q && !busy_q && !start && gnt && req_vec == 2'h0)
        |-> (o_func_gnt.video && !o_func_gnt.audio);
  endproperty
  a_park_video: assert property (p_park_video) else $error("park not on video");

  // request pin is OR in normal mode
  property p_req_or;
    @(posedge i_clk) disable iff (i_rst)
      !lock_en_q |-> (o_req_n == !(i_func_req.video || i_func_req.audio));
  endproperty
  a_req_or: assert property (p_req_or) else $error("request pin not OR");

  // audio request wins an idle grant
  property p_audio_wins;
    @(posedge i_clk) disable iff (i_rst)
      (!lock_en_q && !busy_q && !start && gnt && i_func_req.audio) |-> o_func_gnt.audio;
  endproperty
  a_audio_wins: assert property (p_audio_wins) else $error("audio lost priority");

  property p_no_preempt;
    @(posedge i_clk) disable iff (i_rst)
      (busy_q && !idle && !$changed(lock_en_q)) |=> (!busy_q || $stable(owner_q));
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("owner changed");

  // grant freezes decision one cycle later
  property p_freeze;
    @(posedge i_clk) disable iff (i_rst)
      (lock_en_q && i_chipset_request_lock_enable && !locked_q && gnt)
        |=> (locked_q && owner_q == $past(sel));
  endproperty
  a_freeze: assert property (p_freeze) else $error("decision not frozen");

  property p_owner_req;
    @(posedge i_clk) disable iff (i_rst)
      (lock_en_q && locked_q) |-> (o_req_n == !req_vec[owner_q]);
  endproperty
  a_owner_req: assert property (p_owner_req) else $error("other request leaked");

  property p_release;
    @(posedge i_clk) disable iff (i_rst)
      (locked_q && idle) |=> !locked_q;
  endproperty
  a_release: assert property (p_release) else $error("lock not released");

  property p_gate;
    @(posedge i_clk) disable iff (i_rst)
      (gate_en_q && o_req_n) |-> (o_func_gnt == 2'h0);
  endproperty
  a_gate: assert property (p_gate) else $error("grant passed without request");

  property p_mode_sample;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> (lock_en_q == $past(i_chipset_request_lock_enable));
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("mode bit not sampled");

endmodule // dfarb_arbiter

// ### verilog/dfarb_pkg.sv
// Purpose: shared types and constants for the dual function request arbiter
// Assumes: all bus signals are synchronous to the pci clock
// Notes: internal requests and grants are active high, pins active low
package dfarb_pkg;

  // function index of each bus master
  localparam logic FUNC_VIDEO = 1'b0;
  localparam logic FUNC_AUDIO = 1'b1;

  // reset values of the arbiter state
  localparam logic RST_LOCKED = 1'b0;
  localparam logic RST_BUSY = 1'b0;
  localparam logic RST_OWNER = FUNC_VIDEO;
  localparam logic RST_MODE = 1'b0;

  // one bit per function, indexed by the function number
  typedef struct packed {
    logic audio;
    logic video;
  } dfarb_func_s;

  // pci bus phase signals, active low as on the pins
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
  } dfarb_bus_s;

endpackage
